/* File: psram_burst_core.sv */
`timescale 1ns/1ps
`include "psram_xfer_defs.svh"

module psram_burst_core
   import psram_xfer_pkg::*;
(
   // system
   input  wire logic                 REF_CLK,
   input  wire logic                 RSTN,
   // memory pins
   input  wire logic                 CLK,
   input  wire logic                 CE_N,
   input  wire logic                 ADDRESS_VALID_STROBE_N,
   input  wire logic                 WE_N,
   input  wire logic                 OE_N,
   input  wire logic [`ADDR_W-1:0]   ADDR,
   input  wire logic [`DATA_W-1:0]   DQ_I,
   output logic      [`DATA_W-1:0]   DQ_O,
   output logic                      DQ_OE,
   output logic                      WAIT,
   // configuration
   input  wire logic [15:0]          BUS_CONFIG_WORD,
   // status
   output logic                      SELECT_LOW_OVERRUN,
   output logic                      MODE_SWITCH_ERR,
   output logic                      SELECT_HIGH_GAP_ERR,
   output logic                      REFRESH_BUSY
);
   localparam int PW = 5 + `ADDR_W + `DATA_W;

   // ==================================================
   // pin synchronisers
   logic [PW-1:0] meta_ff, sync_ff;
   logic          clk_prev_ff, ce_prev_ff;
   logic          s_clk, s_ce, s_adv, s_we, s_oe;
   logic [`ADDR_W-1:0] s_addr;
   logic [`DATA_W-1:0] s_dq;

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         meta_ff     <= {5'h0F, {(`ADDR_W + `DATA_W){1'b0}}};
         sync_ff     <= {5'h0F, {(`ADDR_W + `DATA_W){1'b0}}};
         clk_prev_ff <= 1'b0;
         ce_prev_ff  <= 1'b0;
      end else begin
         meta_ff     <= {CLK, CE_N, ADDRESS_VALID_STROBE_N, WE_N, OE_N, ADDR, DQ_I};
         sync_ff     <= meta_ff;
         clk_prev_ff <= s_clk;
         ce_prev_ff  <= s_ce;
      end
   end

   assign {s_clk, s_ce, s_adv, s_we, s_oe, s_addr, s_dq} =
          {sync_ff[PW-1], ~sync_ff[PW-2], ~sync_ff[PW-3], sync_ff[PW-4], ~sync_ff[PW-5],
           sync_ff[`ADDR_W+`DATA_W-1:0]};

   logic       clk_rise, ce_fall, ce_rise;
   logic [2:0] lat_code;
   logic       lat_fixed, sync_mode;

   assign clk_rise  = s_clk & ~clk_prev_ff;
   assign ce_fall   = s_ce & ~ce_prev_ff;
   assign ce_rise   = ~s_ce & ce_prev_ff;
   assign lat_code  = BUS_CONFIG_WORD[`CFG_LAT_HI:`CFG_LAT_LO];
   assign lat_fixed = BUS_CONFIG_WORD[`CFG_LAT_FIXED_BIT];
   assign sync_mode = ~BUS_CONFIG_WORD[`CFG_MODE_BIT];

   // ==================================================
   // array, write buffer, refresh engine
   logic [`DATA_W-1:0] mem [`MEM_DEPTH];
   wr_stream_if #(.WIDTH(24)) wq ();

   wr_fifo #(.WIDTH(24), .DEPTH(`FIFO_DEPTH)) u_wr_fifo (
      .clk   (REF_CLK),
      .rst_n (RSTN),
      .f     (wq)
   );

   logic [7:0]  ref_tmr_ff, nxt_ref_tmr;
   logic        ref_req_ff, nxt_ref_req;
   logic [2:0]  ref_busy_ff, nxt_ref_busy;
   logic [11:0] low_cnt_ff, nxt_low_cnt;
   logic [11:0] high_cnt_ff, nxt_high_cnt;
   logic        overrun_ff, nxt_overrun;
   logic        refresh_op;

   // array is stalled while a refresh runs; the buffer absorbs incoming writes
   assign wq.out_ready = (ref_busy_ff == 3'h0);

   always_ff @(posedge REF_CLK) begin
      if (wq.out_valid && wq.out_ready) begin
         mem[wq.out_data[23:16]] <= wq.out_data[15:0];
      end
   end

   always_comb begin
      nxt_ref_tmr  = ref_tmr_ff + 8'h01;
      nxt_ref_req  = ref_req_ff;
      nxt_ref_busy = (ref_busy_ff != 3'h0) ? ref_busy_ff - 3'h1 : 3'h0;
      if (ref_tmr_ff == 8'(`REFRESH_PERIOD_CYC - 1)) begin
         nxt_ref_tmr = 8'h00;
         nxt_ref_req = 1'b1;
      end
      // clocked select-high or long enough select-high
      refresh_op = ref_req_ff & ~s_ce & (clk_rise | (high_cnt_ff >= 12'(`REFRESH_HIGH_CYC)));
      if (refresh_op) begin
         nxt_ref_req  = 1'b0;
         nxt_ref_busy = 3'(`REFRESH_BUSY_CYC);
      end
      nxt_low_cnt  = s_ce ? ((low_cnt_ff == 12'hFFF) ? low_cnt_ff : low_cnt_ff + 12'h001) : 12'h000;
      nxt_high_cnt = s_ce ? 12'h000 : ((high_cnt_ff == 12'hFFF) ? high_cnt_ff : high_cnt_ff + 12'h001);
      // select held low past the maximum interval
      nxt_overrun  = overrun_ff | (s_ce & (low_cnt_ff >= 12'(`MAX_SELECT_LOW_CYC)));
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         ref_tmr_ff  <= 8'h00;
         ref_req_ff  <= 1'b0;
         ref_busy_ff <= 3'h0;
         low_cnt_ff  <= 12'h000;
         high_cnt_ff <= 12'h000;
         overrun_ff  <= 1'b0;
      end else begin
         ref_tmr_ff  <= nxt_ref_tmr;
         ref_req_ff  <= nxt_ref_req;
         ref_busy_ff <= nxt_ref_busy;
         low_cnt_ff  <= nxt_low_cnt;
         high_cnt_ff <= nxt_high_cnt;
         overrun_ff  <= nxt_overrun;
      end
   end

   // ==================================================
   // access sequencer
   xfer_state_t        state_ff, nxt_state;
   op_kind_t           last_op_ff, nxt_last_op;
   logic               last_var_ff, nxt_last_var;
   logic [4:0]         lat_ff, nxt_lat;
   logic [`ADDR_W-1:0] addr_ff, nxt_addr;
   logic [7:0]         words_ff, nxt_words;
   logic               is_read_ff, nxt_is_read;
   logic [`DATA_W-1:0] dq_ff, nxt_dq;
   logic               oe_ff, nxt_oe;
   logic               wait_ff, nxt_wait;
   logic               went_high_ff, nxt_went_high;
   logic               need_gap_ff, nxt_need_gap;
   logic               mode_err_ff, nxt_mode_err;
   logic               gap_err_ff, nxt_gap_err;
   logic               burst_start, wait_act, collide;
   logic [4:0]         first_lat;

   always_comb begin
      nxt_state     = state_ff;
      nxt_last_op   = last_op_ff;
      nxt_last_var  = last_var_ff;
      nxt_lat       = lat_ff;
      nxt_addr      = addr_ff;
      nxt_words     = words_ff;
      nxt_is_read   = is_read_ff;
      nxt_dq        = dq_ff;
      nxt_went_high = went_high_ff | ~s_ce;
      nxt_need_gap  = need_gap_ff;
      nxt_mode_err  = mode_err_ff;
      nxt_gap_err   = gap_err_ff;
      wq.in_valid   = 1'b0;
      wq.in_data    = {addr_ff, s_dq};
      collide       = ref_req_ff | (ref_busy_ff != 3'h0);
      // variable = code + 2; fixed = code + 1; write = code
      first_lat     = ~s_we ? {2'b00, lat_code} : (lat_fixed ? 5'(lat_code) + 5'h01 : 5'(lat_code) + 5'h02);
      // refresh collision on a variable-latency read adds one more code of clocks
      if (s_we && !lat_fixed && collide) begin
         first_lat = first_lat + 5'(lat_code);
      end
      // new burst only in idle, during an async write, or after the first word moved
      burst_start = clk_rise & s_ce & s_adv &
                    ((state_ff == S_IDLE) || (state_ff == S_AWR) ||
                     (((state_ff == S_RD) || (state_ff == S_WR)) && (words_ff != 8'h00)));
      // ce ends an async write here, so the gap is owed next
      if (ce_rise && (state_ff == S_AWR)) begin
         nxt_need_gap = 1'b1;
      end
      // gap owed after async write in sync mode or ce-ended writes
      if (ce_fall) begin
         if (need_gap_ff && (high_cnt_ff < 12'(`MIN_SELECT_HIGH_GAP_CYC))) begin
            nxt_gap_err = 1'b1;
         end
         nxt_need_gap = 1'b0;
      end
      if (!s_ce) begin
         nxt_state = S_IDLE;
         nxt_oe    = 1'b0;
      end else begin
         nxt_oe = 1'b0;
         if (burst_start) begin
            if ((last_op_ff == OP_ASYNC) && !lat_fixed && !went_high_ff) begin
               nxt_mode_err = 1'b1;
            end
            if (state_ff == S_AWR) begin
               wq.in_valid = wq.in_ready;
            end
            nxt_state     = (first_lat == 5'h00) ? (s_we ? S_RD : S_WR) : S_LAT;
            nxt_lat       = first_lat;
            nxt_addr      = s_addr;
            nxt_words     = 8'h00;
            nxt_is_read   = s_we;
            nxt_last_op   = OP_BURST;
            nxt_last_var  = ~lat_fixed;
            nxt_went_high = 1'b0;
            nxt_dq        = mem[s_addr];
         end else begin
            case (state_ff)
               S_IDLE: begin
                  if (!s_we) begin
                     if ((last_op_ff == OP_BURST) && last_var_ff && !went_high_ff) begin
                        nxt_mode_err = 1'b1;
                     end
                     nxt_state     = S_AWR;
                     nxt_addr      = s_addr;
                     nxt_last_op   = OP_ASYNC;
                     nxt_went_high = 1'b0;
                  end else if (s_oe) begin
                     nxt_dq      = mem[s_addr];
                     nxt_oe      = 1'b1;
                     nxt_last_op = OP_ASYNC;
                     nxt_gap_err = nxt_gap_err | need_gap_ff;
                  end
               end
               S_AWR: begin
                  // strobe-ended write: commit on write-enable release
                  if (s_we) begin
                     wq.in_valid = wq.in_ready;
                     nxt_state   = S_IDLE;
                     nxt_need_gap = sync_mode;
                  end
               end
               S_LAT: begin
                  if (clk_rise) begin
                     nxt_lat = lat_ff - 5'h01;
                     if (lat_ff == 5'h01) begin
                        nxt_state = is_read_ff ? S_RD : S_WR;
                        nxt_dq    = mem[addr_ff];
                     end
                  end
               end
               S_RD: begin
                  nxt_oe = s_oe;
                  // write strobe leaves the burst for an async write
                  if (!s_we) begin
                     nxt_state = S_IDLE;
                  end
                  if (clk_rise) begin
                     nxt_addr  = addr_ff + 1'b1;
                     nxt_words = (words_ff == 8'hFF) ? words_ff : words_ff + 8'h01;
                     nxt_dq    = mem[addr_ff + 1'b1];
                  end
               end
               S_WR: begin
                  if (clk_rise && wq.in_ready) begin
                     wq.in_valid = 1'b1;
                     nxt_addr    = addr_ff + 1'b1;
                     nxt_words   = (words_ff == 8'hFF) ? words_ff : words_ff + 8'h01;
                  end
               end
               default: nxt_state = S_IDLE;
            endcase
         end
         if (state_ff == S_AWR && !s_ce) begin
            wq.in_valid = wq.in_ready;
         end
      end
      if (ce_rise && (state_ff == S_AWR)) begin
         wq.in_valid = wq.in_ready;
      end
      // during delay, or released one clock ahead
      wait_act = ((nxt_state == S_LAT) &&
                  !(BUS_CONFIG_WORD[`CFG_WAIT_EARLY_BIT] && (nxt_lat == 5'h01))) ||
                 ((nxt_state == S_WR) && !wq.in_ready);
      nxt_wait = BUS_CONFIG_WORD[`CFG_WAIT_POL_BIT] ? wait_act : ~wait_act;
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         state_ff     <= S_IDLE;
         last_op_ff   <= OP_NONE;
         last_var_ff  <= 1'b0;
         lat_ff       <= 5'h00;
         addr_ff      <= '0;
         words_ff     <= 8'h00;
         is_read_ff   <= 1'b0;
         dq_ff        <= '0;
         oe_ff        <= 1'b0;
         wait_ff      <= 1'b0;
         went_high_ff <= 1'b1;
         need_gap_ff  <= 1'b0;
         mode_err_ff  <= 1'b0;
         gap_err_ff   <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         last_op_ff   <= nxt_last_op;
         last_var_ff  <= nxt_last_var;
         lat_ff       <= nxt_lat;
         addr_ff      <= nxt_addr;
         words_ff     <= nxt_words;
         is_read_ff   <= nxt_is_read;
         dq_ff        <= nxt_dq;
         oe_ff        <= nxt_oe;
         wait_ff      <= nxt_wait;
         went_high_ff <= nxt_went_high;
         need_gap_ff  <= nxt_need_gap;
         mode_err_ff  <= nxt_mode_err;
         gap_err_ff   <= nxt_gap_err;
      end
   end

   assign DQ_O                = dq_ff;
   assign DQ_OE               = oe_ff;
   assign WAIT                = wait_ff;
   assign SELECT_LOW_OVERRUN  = overrun_ff;
   assign MODE_SWITCH_ERR     = mode_err_ff;
   assign SELECT_HIGH_GAP_ERR = gap_err_ff;
   assign REFRESH_BUSY        = (ref_busy_ff != 3'h0);
endmodule

/* File: psram_xfer_defs.svh */
`ifndef PSRAM_XFER_DEFS_SVH
`define PSRAM_XFER_DEFS_SVH

// ==================================================
// configuration word fields
`define CFG_MODE_BIT        15
`define CFG_LAT_FIXED_BIT   14
`define CFG_LAT_HI          13
`define CFG_LAT_LO          11
`define CFG_WAIT_POL_BIT    10
`define CFG_WAIT_EARLY_BIT  8
`define CFG_RESET_VALUE     16'h9D1F

// ==================================================
// timing, derived at the system clock rate
`define CLK_MHZ                   40
`define MIN_SELECT_HIGH_GAP_NS    5
`define MIN_SELECT_HIGH_GAP_CYC   (((`MIN_SELECT_HIGH_GAP_NS * `CLK_MHZ) + 999) / 1000)
`define REFRESH_HIGH_NS           15
`define REFRESH_HIGH_CYC          (((`REFRESH_HIGH_NS * `CLK_MHZ) / 1000) + 1)
`define MAX_SELECT_LOW_NS         4000
`define MAX_SELECT_LOW_CYC        ((`MAX_SELECT_LOW_NS * `CLK_MHZ) / 1000)
`define REFRESH_PERIOD_CYC        200
`define REFRESH_BUSY_CYC          4

// ==================================================
// geometry
`define ADDR_W      8
`define DATA_W      16
`define MEM_DEPTH   256
`define FIFO_DEPTH  32

`endif

/* File: psram_xfer_pkg.sv */
package psram_xfer_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_LAT  = 3'b001,
      S_RD   = 3'b010,
      S_WR   = 3'b011,
      S_AWR  = 3'b100
   } xfer_state_t;

   typedef enum logic [1:0] {
      OP_NONE  = 2'b00,
      OP_ASYNC = 2'b01,
      OP_BURST = 2'b10
   } op_kind_t;

   typedef logic [23:0] wr_word_t;
endpackage

/* File: wr_stream_if.sv */
`timescale 1ns/1ps
interface wr_stream_if #(parameter int WIDTH = 24);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;

   modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user   (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* File: wr_fifo.sv */
`timescale 1ns/1ps
module wr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input wire logic   clk,
   input wire logic   rst_n,
   wr_stream_if.buffer f
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0]    wr_ptr_ff, nxt_wr_ptr;
   logic [AW-1:0]    rd_ptr_ff, nxt_rd_ptr;
   logic [AW:0]      count_ff,  nxt_count;
   logic             push;
   logic             pop;

   assign f.in_ready  = (count_ff != (AW+1)'(DEPTH));
   assign f.out_valid = (count_ff != '0);
   assign f.out_data  = store[rd_ptr_ff];

   always_comb begin
      push       = f.in_valid & f.in_ready;
      pop        = f.out_valid & f.out_ready;
      nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      nxt_count  = count_ff;
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff  <= nxt_count;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr_ff] <= f.in_data;
      end
   end
endmodule

/* File: psram_burst_core_properties.sv */
`timescale 1ns/1ps
`include "psram_xfer_defs.svh"
// ==================================================
// port-level checks on the burst memory core
module psram_burst_core_checker (
   // system
   input wire logic                 REF_CLK,
   input wire logic                 RSTN,
   // pins
   input wire logic                 CE_N,
   input wire logic                 OE_N,
   input wire logic [`DATA_W-1:0]   DQ_O,
   input wire logic                 DQ_OE,
   input wire logic                 WAIT,
   // configuration and status
   input wire logic [15:0]          BUS_CONFIG_WORD,
   input wire logic                 SELECT_LOW_OVERRUN,
   input wire logic                 MODE_SWITCH_ERR,
   input wire logic                 SELECT_HIGH_GAP_ERR,
   input wire logic                 REFRESH_BUSY
);
   localparam int LO_MIN = `MAX_SELECT_LOW_CYC;
   localparam int LO_MAX = `MAX_SELECT_LOW_CYC + 8;
   logic [8:0] low_cnt_ff;
   logic [8:0] nxt_low_cnt;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);

   // ==================================================
   // select-low time seen at the pin, saturating
   always_comb begin
      nxt_low_cnt = low_cnt_ff;
      if (CE_N) begin
         nxt_low_cnt = 9'h000;
      end else if (low_cnt_ff != 9'h1FF) begin
         nxt_low_cnt = low_cnt_ff + 9'h001;
      end
   end
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         low_cnt_ff <= 9'h000;
      end else begin
         low_cnt_ff <= nxt_low_cnt;
      end
   end

   // ==================================================
   // assertions
   a_reset_quiet: assert property (@(posedge REF_CLK) disable iff (1'b0)
      !RSTN |=> (DQ_O == 16'h0000 && !DQ_OE && !WAIT && !REFRESH_BUSY && !SELECT_LOW_OVERRUN
                 && !MODE_SWITCH_ERR && !SELECT_HIGH_GAP_ERR)) else $error("outputs not cleared by reset");
   a_overrun_sticky: assert property (SELECT_LOW_OVERRUN |=> SELECT_LOW_OVERRUN)
      else $error("overrun flag cleared");
   a_overrun_cause: assert property ($rose(SELECT_LOW_OVERRUN) |-> low_cnt_ff >= LO_MIN && low_cnt_ff <= LO_MAX)
      else $error("overrun flag at wrong select-low time");
   a_mode_sticky: assert property (!$fell(MODE_SWITCH_ERR))
      else $error("mode switch flag cleared");
   a_gap_sticky: assert property ($rose(SELECT_HIGH_GAP_ERR) |=> SELECT_HIGH_GAP_ERR [*8])
      else $error("gap flag cleared");
   a_idle_quiet: assert property (CE_N [*5] |-> !DQ_OE)
      else $error("data driven while deselected");
   a_oe_gate: assert property (OE_N [*5] |-> !DQ_OE)
      else $error("data driven with output strobe high");
   a_wait_idle: assert property (CE_N [*5] |-> WAIT == !BUS_CONFIG_WORD[10])
      else $error("wait not at its idle level");
   a_refresh_len: assert property ($rose(REFRESH_BUSY) |-> REFRESH_BUSY [*4] ##1 !REFRESH_BUSY)
      else $error("refresh length wrong");
endmodule

bind psram_burst_core psram_burst_core_checker chk (
   .REF_CLK(REF_CLK), .RSTN(RSTN), .CE_N(CE_N), .OE_N(OE_N), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .WAIT(WAIT),
   .BUS_CONFIG_WORD(BUS_CONFIG_WORD), .SELECT_LOW_OVERRUN(SELECT_LOW_OVERRUN),
   .MODE_SWITCH_ERR(MODE_SWITCH_ERR), .SELECT_HIGH_GAP_ERR(SELECT_HIGH_GAP_ERR), .REFRESH_BUSY(REFRESH_BUSY)
);

/* File: psram_host_model.sv */
`timescale 1ns/1ps
// ==================================================
// memory controller stand-in on the burst bus
module psram_host_model (
   // system
   input  wire logic        ref_clk,
   // pins toward the memory
   output logic             clk_pin,
   output logic             ce_n,
   output logic             adv_n,
   output logic             we_n,
   output logic             oe_n,
   output logic [7:0]       addr,
   output logic [15:0]      dq_i
);
   initial begin
      clk_pin = 1'b0;
      ce_n = 1'b1;
      adv_n = 1'b1;
      we_n = 1'b1;
      oe_n = 1'b1;
      addr = 8'h00;
      dq_i = 16'h0000;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask

   // one 200 ns link clock, only inside frames
   task automatic pulse(input logic [15:0] d);
      dq_i = d;
      clk_pin = 1'b1;
      wt(4);
      clk_pin = 1'b0;
      wt(4);
   endtask

   // select may stay low into a new burst
   task automatic start(input logic [7:0] a, input logic wr);
      ce_n = 1'b0;
      adv_n = 1'b0;
      we_n = !wr;
      oe_n = 1'b1;
      addr = a;
      pulse(~dq_i);
      adv_n = 1'b1;
      addr = ~a;
      oe_n = wr;
   endtask

   // select level held, released lines toggle
   task automatic sel(input logic lvl, input int n);
      ce_n = lvl;
      adv_n = 1'b1;
      we_n = 1'b1;
      oe_n = 1'b1;
      addr = ~addr;
      dq_i = ~dq_i;
      wt(n);
   endtask

   // write ended by the write strobe, select stays low
   task automatic async_wr(input logic [7:0] a, input logic [15:0] d);
      oe_n = 1'b1;
      adv_n = 1'b1;
      ce_n = 1'b0;
      addr = a;
      dq_i = d;
      wt(2);
      we_n = 1'b0;
      wt(6);
      we_n = 1'b1;
      wt(2);
      dq_i = ~d;
   endtask

   // leaves the output strobe low so the caller can sample
   task automatic async_rd(input logic [7:0] a);
      we_n = 1'b1;
      adv_n = 1'b1;
      ce_n = 1'b0;
      addr = a;
      wt(2);
      oe_n = 1'b0;
      wt(6);
   endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [15:0] cfg = 16'h1000;
   logic        clk_pin, ce_n, adv_n, we_n, oe_n, dq_oe, wait_pin;
   logic [7:0]  addr;
   logic [15:0] dq_i, dq_o;
   logic        overrun, mode_err, gap_err, refresh_busy;
   logic [15:0] exp [256];
   int          errors = 0;
   int          comparisons = 0;

   always #12.5 ref_clk = ~ref_clk;

   psram_host_model ctl (.ref_clk(ref_clk), .clk_pin(clk_pin), .ce_n(ce_n), .adv_n(adv_n), .we_n(we_n),
      .oe_n(oe_n), .addr(addr), .dq_i(dq_i));
   psram_burst_core dut (.REF_CLK(ref_clk), .RSTN(rstn), .CLK(clk_pin), .CE_N(ce_n),
      .ADDRESS_VALID_STROBE_N(adv_n), .WE_N(we_n), .OE_N(oe_n), .ADDR(addr), .DQ_I(dq_i), .DQ_O(dq_o),
      .DQ_OE(dq_oe), .WAIT(wait_pin), .BUS_CONFIG_WORD(cfg), .SELECT_LOW_OVERRUN(overrun),
      .MODE_SWITCH_ERR(mode_err), .SELECT_HIGH_GAP_ERR(gap_err), .REFRESH_BUSY(refresh_busy));

   // ==================================================
   // shared tasks
   task automatic stop_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      comparisons++;
      if (seen !== want) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic do_reset(input logic [15:0] c);
      ctl.sel(1'b1, 1);
      cfg = c;
      rstn = 1'b0;
      ctl.wt(3);
      rstn = 1'b1;
      ctl.wt(4);
   endtask

   // burst of n words; the first word comes lat clocks after the address clock for reads, lat + 1 for writes
   task automatic burst(input logic [7:0] a, input logic wr, input int lat, input int n);
      logic [7:0] ad;
      int         off;
      off = wr ? lat + 1 : lat;
      ctl.start(a, wr);
      for (int k = 1; k < off + n; k++) begin
         ad = a + 8'(k - off);
         if (wr && k >= off) exp[ad] = {~ad, ad};
         ctl.pulse((wr && k >= off) ? exp[ad] : ~ctl.dq_i);
         if (k == lat - 1) check("wait held", 16'(wait_pin), 16'(cfg[10] ^ cfg[8]));
         if (k == lat) check("wait free", 16'(wait_pin), 16'(!cfg[10]));
         if (!wr && k >= off) check("burst word", dq_o, exp[ad]);
      end
   endtask

   // ==================================================
   // tests
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      stop_test();
   end

   initial begin
      do_reset(16'h1000);
      check("flags", 16'({overrun, mode_err, gap_err}), 16'h0000);
      check("wait idle", 16'(wait_pin), 16'h0001);
      burst(8'h10, 1'b1, 2, 3);
      burst(8'h20, 1'b1, 2, 1);
      ctl.sel(1'b1, 2);
      burst(8'h10, 1'b0, 4, 3);
      burst(8'h20, 1'b0, 4, 1);
      ctl.sel(1'b1, 30);
      check("no mode error", 16'(mode_err), 16'h0000);
      exp[8'h30] = 16'hA5C3;
      ctl.async_wr(8'h30, exp[8'h30]);
      ctl.async_rd(8'h30);
      check("async word", dq_o, exp[8'h30]);
      check("gap error", 16'(gap_err), 16'h0001);
      burst(8'h30, 1'b0, 4, 1);
      ctl.sel(1'b1, 4);
      check("mode error", 16'(mode_err), 16'h0001);

      do_reset(16'h5400);
      exp[8'h40] = 16'h5A3C;
      ctl.async_wr(8'h40, exp[8'h40]);
      burst(8'h40, 1'b0, 3, 1);
      exp[8'h41] = 16'h0FF0;
      ctl.async_wr(8'h41, exp[8'h41]);
      ctl.sel(1'b1, 4);
      ctl.async_rd(8'h41);
      check("write after burst", dq_o, exp[8'h41]);
      check("fixed no mode error", 16'(mode_err), 16'h0000);
      ctl.sel(1'b0, 100);
      ctl.sel(1'b1, 2);
      ctl.sel(1'b0, 150);
      check("no overrun", 16'(overrun), 16'h0000);
      ctl.wt(30);
      check("overrun", 16'(overrun), 16'h0001);

      do_reset(16'h9100);
      exp[8'h50] = 16'h3CC3;
      ctl.async_wr(8'h50, exp[8'h50]);
      ctl.async_rd(8'h50);
      check("async mode word", dq_o, exp[8'h50]);
      check("no gap error", 16'(gap_err), 16'h0000);
      ctl.sel(1'b1, 4);
      burst(8'h50, 1'b0, 4, 1);
      ctl.sel(1'b1, 4);
      stop_test();
   end
endmodule
